/* input_gearbox_deserializer.sv */
/*
  Input gearbox of a bottom-edge io cell group: serial to parallel in one
  7-bit video, one 8-bit or two independent 4-bit configurations.
  Assumes the fast edge clock and serial data arrive asynchronously and are
  slow enough (half period well above two sys_clk periods) to be oversampled.
*/
`timescale 1ns/1ns
module input_gearbox_deserializer
  import gearbox_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Pins: edge clock and delayed serial data of io logic cells
  input wire gear_pins_type pins,
  // Core control
  input wire gear_ctrl_type ctrl,
  // Parallel words to the core
  output logic [OUT_W-1:0] q,
  output logic word_valid
);

  logic [2:0] sync1_r, sync1_nxt;
  logic [2:0] sync2_r, sync2_nxt;
  logic clk_prev_r, clk_prev_nxt;
  logic [1:0] req_prev_r, req_prev_nxt;
  logic [OUT_W-1:0] q_r, q_nxt;
  logic valid_r, valid_nxt;
  logic bit_strobe;
  logic [3:0] width_first;
  logic [1:0] align_pulse;
  logic [OUT_W-1:0] word_first, word_third;
  logic upd_first, upd_third;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage feeds only the second
  always_comb begin
    sync1_nxt = {pins.fast_edge_clock, pins.data_first, pins.data_third};
    sync2_nxt = sync1_r;
    clk_prev_nxt = sync2_r[2];
    req_prev_nxt = {ctrl.word_align_request_first, ctrl.word_align_request_third};
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      clk_prev_r <= 1'b0;
      req_prev_r <= 2'h0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      clk_prev_r <= clk_prev_nxt;
      req_prev_r <= req_prev_nxt;
    end
  end

  // Either edge of the edge clock is one bit time
  assign bit_strobe = sync2_r[2] ^ clk_prev_r;

  // Core request is on sys_clk already; rising edge makes one slip
  assign align_pulse[1] = ctrl.word_align_request_first & ~req_prev_r[1];
  assign align_pulse[0] = ctrl.word_align_request_third & ~req_prev_r[0];

  ////////////////////////////////////////////////////////////////////////////
  // Width of the first lane follows the mode
  always_comb begin
    unique case (ctrl.mode)
      MODE_VIDEO7: width_first = WIDTH_VIDEO;
      MODE_GEAR8: width_first = WIDTH_EIGHT;
      MODE_DUAL4: width_first = WIDTH_FOUR;
      default: width_first = WIDTH_EIGHT; // Unused code behaves as 8-bit
    endcase
  end

  // Stages one and two; first lane fed from the first io logic cell
  gearbox_lane lane_first (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .bit_strobe(bit_strobe),
    .serial_bit(sync2_r[1]),
    .word_width(width_first),
    .align_pulse(align_pulse[1]),
    .aligned_word(word_first),
    .update_pulse(upd_first)
  );

  // Second 4-bit lane, only meaningful in dual mode
  gearbox_lane lane_third (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .bit_strobe(bit_strobe),
    .serial_bit(sync2_r[0]),
    .word_width(WIDTH_FOUR),
    .align_pulse(align_pulse[0]),
    .aligned_word(word_third),
    .update_pulse(upd_third)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Stage three: hand words to the core on the word-rate enable
  always_comb begin
    q_nxt = q_r;
    valid_nxt = 1'b0;
    unique case (ctrl.mode)
      MODE_VIDEO7: begin
        if (upd_first) begin
          q_nxt = {1'b0, word_first[6:0]};
          valid_nxt = 1'b1;
        end
      end
      MODE_DUAL4: begin
        // Halves update on their own strobes; both share one edge clock
        if (upd_first) begin
          q_nxt[OUT_W-1:HALF_W] = word_first[HALF_W-1:0];
        end
        if (upd_third) begin
          q_nxt[HALF_W-1:0] = word_third[HALF_W-1:0];
        end
        valid_nxt = upd_first | upd_third;
      end
      default: begin
        if (upd_first) begin
          q_nxt = word_first;
          valid_nxt = 1'b1;
        end
      end
    endcase
  end

  // Three register stages in total: capture, align, this one
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q_r <= WORD_RESET;
      valid_r <= 1'b0;
    end else begin
      q_r <= q_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign q = q_r;
  assign word_valid = valid_r;

endmodule : input_gearbox_deserializer

/* gearbox_pkg.sv */
/*
  Shared constants, mode encoding and carrier types of the input gearbox.
  Assumes nothing beyond a SystemVerilog compiler; imported whole by each module.
*/
package gearbox_pkg;

  // Word widths per configuration
  localparam logic [3:0] WIDTH_VIDEO = 4'h7;
  localparam logic [3:0] WIDTH_EIGHT = 4'h8;
  localparam logic [3:0] WIDTH_FOUR = 4'h4;

  // Capture history depth, two full words
  localparam int HIST_W = 16;
  localparam int OUT_W = 8;
  localparam int HALF_W = 4;

  // Reset values
  localparam logic [OUT_W-1:0] WORD_RESET = 8'h00;
  localparam logic [HIST_W-1:0] HIST_RESET = 16'h0000;
  localparam logic [2:0] PHASE_RESET = 3'h0;
  localparam logic [3:0] COUNT_RESET = 4'h0;

  typedef enum logic [1:0] {
    MODE_VIDEO7 = 2'b00,
    MODE_GEAR8 = 2'b01,
    MODE_DUAL4 = 2'b10
  } gear_mode_type;

  // Control coming from the core logic on sys_clk
  typedef struct packed {
    gear_mode_type mode;
    logic word_align_request_first;
    logic word_align_request_third;
  } gear_ctrl_type;

  // Serial inputs from the two io logic cells, asynchronous to sys_clk
  typedef struct packed {
    logic fast_edge_clock;
    logic data_first;
    logic data_third;
  } gear_pins_type;

endpackage : gearbox_pkg

/* gearbox_lane.sv */
/*
  One deserializer lane: capture history, bit counter, word boundary alignment.
  Assumes bit_strobe is a one-cycle pulse on each edge of the fast edge clock and
  that serial_bit is already synchronised to sys_clk.
*/
`timescale 1ns/1ns
module gearbox_lane
  import gearbox_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Serial side
  input wire logic bit_strobe,
  input wire logic serial_bit,
  // Control
  input wire logic [3:0] word_width,
  input wire logic align_pulse,
  // Aligned word, stage two
  output logic [OUT_W-1:0] aligned_word,
  output logic update_pulse
);

  logic [HIST_W-1:0] hist_r, hist_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic [2:0] align_phase_select_r, align_phase_select_nxt;
  logic [OUT_W-1:0] aligned_r, aligned_nxt;
  logic update_r, update_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Pick width bits ending phase bits back from the newest one
  function automatic logic [OUT_W-1:0] pick_word(input logic [HIST_W-1:0] hist,
                                                 input logic [3:0] width,
                                                 input logic [2:0] phase);
    logic [OUT_W-1:0] word;
    int base;
    word = WORD_RESET;
    base = HIST_W - int'(width) - int'(phase);
    for (int i = 0; i < OUT_W; i++) begin
      if (i < int'(width)) begin
        word[i] = hist[base + i];
      end
    end
    return word;
  endfunction : pick_word

  ////////////////////////////////////////////////////////////////////////////
  // Next state: capture, count, align
  always_comb begin
    hist_nxt = hist_r;
    bit_cnt_nxt = bit_cnt_r;
    align_phase_select_nxt = align_phase_select_r;
    aligned_nxt = aligned_r;
    update_nxt = 1'b0;
    // Oldest bit lands lowest, so first received bit is word bit 0
    if (bit_strobe) begin
      hist_nxt = {serial_bit, hist_r[HIST_W-1:1]};
      if (bit_cnt_r >= word_width - 4'h1) begin
        bit_cnt_nxt = COUNT_RESET;
        update_nxt = 1'b1;
      end else begin
        bit_cnt_nxt = bit_cnt_r + 4'h1;
      end
    end
    // Slip one bit per request, wrapping at the word width
    if (align_pulse) begin
      if ({1'b0, align_phase_select_r} >= word_width - 4'h1) begin
        align_phase_select_nxt = PHASE_RESET;
      end else begin
        align_phase_select_nxt = align_phase_select_r + 3'h1;
      end
    end else if ({1'b0, align_phase_select_r} >= word_width) begin
      align_phase_select_nxt = PHASE_RESET; // Mode changed under us
    end
    // Word latched on the update strobe using the current phase select
    if (update_nxt) begin
      aligned_nxt = pick_word(hist_nxt, word_width, align_phase_select_r);
    end
  end

  // Registers; reset clears capture and alignment state
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hist_r <= HIST_RESET;
      bit_cnt_r <= COUNT_RESET;
      align_phase_select_r <= PHASE_RESET;
      aligned_r <= WORD_RESET;
      update_r <= 1'b0;
    end else begin
      hist_r <= hist_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      align_phase_select_r <= align_phase_select_nxt;
      aligned_r <= aligned_nxt;
      update_r <= update_nxt;
    end
  end

  assign aligned_word = aligned_r;
  assign update_pulse = update_r;

endmodule : gearbox_lane

/* gearbox_assertions.sv */
/* Checker of the gearbox ports, bound to the top module.
   Assumes one sys_clk domain and mode changes only during reset. */
`timescale 1ns/1ns
module gearbox_checker
  import gearbox_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Watched ports
  input wire gear_pins_type pins,
  input wire gear_ctrl_type ctrl,
  input wire logic [OUT_W-1:0] q,
  input wire logic word_valid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic clk_seen_r;
  logic [3:0] since_r;
  // Cycles since the edge clock moved, saturating so idle links stay large
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_seen_r <= 1'b0;
      since_r <= 4'hf;
    end else begin
      clk_seen_r <= pins.fast_edge_clock;
      if (pins.fast_edge_clock != clk_seen_r) since_r <= 4'h0;
      else if (since_r != 4'hf) since_r <= since_r + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_link_idle;
    $stable(pins.fast_edge_clock)[*8];
  endsequence
  property p_reset_clear;
    $rose(reset_n) |-> q == WORD_RESET;
  endproperty
  property p_reset_quiet;
    $rose(reset_n) |-> (!word_valid)[*8];
  endproperty
  property p_pulse;
    word_valid |=> (!word_valid)[*8];
  endproperty
  property p_hold;
    !word_valid |-> $stable(q);
  endproperty
  property p_video_top;
    word_valid && ctrl.mode == MODE_VIDEO7 |-> !q[7];
  endproperty
  property p_edge_latency;
    word_valid |-> since_r inside {[4'h2:4'h6]};
  endproperty
  property p_idle;
    s_link_idle |-> !word_valid;
  endproperty
  property p_align_quiet;
    $rose(ctrl.word_align_request_first) && since_r > 4'h8 |=> $stable(q)[*2];
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("q not clear after reset");
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("word before data");
  a_pulse: assert property (p_pulse)
    else $error("word_valid too long");
  a_hold: assert property (p_hold)
    else $error("q moved without word_valid");
  a_video_top: assert property (p_video_top)
    else $error("q7 set in video mode");
  a_edge_latency: assert property (p_edge_latency)
    else $error("word not tied to a clock edge");
  a_idle: assert property (p_idle)
    else $error("word on idle link");
  a_align_quiet: assert property (p_align_quiet)
    else $error("request changed q");
endmodule : gearbox_checker
bind input_gearbox_deserializer gearbox_checker i_gearbox_checker (.sys_clk(sys_clk),
  .reset_n(reset_n), .pins(pins), .ctrl(ctrl), .q(q), .word_valid(word_valid));

/* serial_source.sv */
/* Serial transmitter model driving edge clock and two data lines.
   Assumes frames of even length, so the clock rests low between them. */
`timescale 1ns/1ns
module serial_source
  import gearbox_pkg::*;
(
  // Link pins toward the gearbox
  output gear_pins_type pins
);
  initial pins = '0;
  // Data changes mid half period, 125 ns clock; lines invert once released
  task automatic send(input logic [31:0] a, input logic [31:0] c, input int n);
    for (int i = 0; i < n; i++) begin
      pins.data_first = a[i];
      pins.data_third = c[i];
      #31;
      pins.fast_edge_clock = ~pins.fast_edge_clock;
      #(31 + i % 2);
    end
    pins.data_first = ~pins.data_first;
    pins.data_third = ~pins.data_third;
  endtask : send
endmodule : serial_source

/* tb.sv */
/* Testbench: each scenario resets the gearbox, sends frames, judges words.
   Assumes serial_source as link partner and the bound checker. */
`timescale 1ns/1ns
module tb
  import gearbox_pkg::*;
;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  gear_ctrl_type ctrl = '{MODE_GEAR8, 1'b0, 1'b0};
  gear_pins_type pins;
  logic [OUT_W-1:0] q;
  logic word_valid;
  logic [7:0] got[$];
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  initial forever #5 sys_clk = ~sys_clk;
  serial_source i_serial_source (.pins(pins));
  input_gearbox_deserializer i_input_gearbox_deserializer (.sys_clk(sys_clk),
    .reset_n(reset_n), .pins(pins), .ctrl(ctrl), .q(q), .word_valid(word_valid));
  // Collect handed-over words; cut a hang short
  always @(posedge sys_clk) begin
    if (word_valid === 1'b1) got.push_back(q);
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  // Word ending at bit e, moved p bits back; bits before reset read zero
  function automatic logic [7:0] pick(logic [63:0] s, int e, int p, int w);
    pick = 8'h00;
    for (int i = 0; i < w; i++) if (e - p - w + i >= 0) pick[i] = s[e - p - w + i];
  endfunction : pick
  task automatic restart(input gear_mode_type m);
    reset_n <= 1'b0;
    ctrl <= '{m, 1'b0, 1'b0};
    repeat (16) @(posedge sys_clk);
    check(q, WORD_RESET);
    reset_n <= 1'b1;
    got.delete();
    repeat (2) @(posedge sys_clk);
  endtask : restart
  task automatic req(input bit third, input int hold);
    @(posedge sys_clk);
    if (third) ctrl.word_align_request_third <= 1'b1;
    else ctrl.word_align_request_first <= 1'b1;
    repeat (hold) @(posedge sys_clk);
    ctrl.word_align_request_third <= 1'b0;
    ctrl.word_align_request_first <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : req
  // Width 4 means dual lanes: first lane high nibble, third lane low
  task automatic judge(input logic [63:0] a, c, input int n, w, pa, pc, k0);
    logic [7:0] e;
    repeat (12) @(posedge sys_clk);
    check(8'(got.size()), 8'(n));
    for (int k = k0; k < n; k++) begin
      e = pick(a, w * k + w, pa, w);
      if (w == 4) e = (e << 4) | pick(c, 4 * k + 4, pc, 4);
      check(got[k], e);
    end
  endtask : judge
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_gear8();
    restart(MODE_GEAR8);
    i_serial_source.send(32'ha5c3_17e9, 32'hffff_0000, 32);
    judge(32'ha5c3_17e9, 0, 4, 8, 0, 0, 0);
  endtask : t_gear8
  task automatic t_video();
    restart(MODE_VIDEO7);
    i_serial_source.send(32'hfb6d_3a5c, 32'h0, 28);
    judge(32'hfb6d_3a5c, 0, 4, 7, 0, 0, 0);
  endtask : t_video
  task automatic t_dual();
    restart(MODE_DUAL4);
    i_serial_source.send(32'hc93e, 32'h5a71, 16);
    judge(32'hc93e, 32'h5a71, 4, 4, 0, 0, 0);
  endtask : t_dual
  // Held request still slips only one bit
  task automatic t_align();
    restart(MODE_GEAR8);
    i_serial_source.send(32'h6e2d, 32'h0, 16);
    judge(32'h6e2d, 0, 2, 8, 0, 0, 0);
    req(1'b0, 4);
    i_serial_source.send(32'hb417, 32'h0, 16);
    judge(64'hb417_6e2d, 0, 4, 8, 1, 0, 2);
  endtask : t_align
  // Four slips wrap the third lane; the first lane keeps its own phase
  task automatic t_wrap();
    restart(MODE_DUAL4);
    repeat (4) req(1'b1, 1);
    req(1'b0, 1);
    i_serial_source.send(32'h9c35, 32'he1b8, 16);
    judge(32'h9c35, 32'he1b8, 4, 4, 1, 0, 0);
  endtask : t_wrap
  initial begin
    t_gear8();
    t_video();
    t_dual();
    t_align();
    t_wrap();
    conclude();
  end
endmodule : tb
